// ===== hw/sample_fifo.sv
// Sample buffer with registered read data
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic [WIDTH-1:0] out_reg, out_next;
  logic out_valid_reg, out_valid_next;
  logic push, pop, full;

  // ------------------------------------------------------------
  // Pointers and output stage
  // ------------------------------------------------------------
  always_comb begin
    // Output stage counts toward the depth
    full = ((count_reg + (AW+1)'(out_valid_reg)) == (AW+1)'(DEPTH));
    push = in_valid_i && !full;
    pop = (count_reg != '0) && (!out_valid_reg || out_ready_i);
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    out_next = out_reg;
    out_valid_next = out_valid_reg;
    if (out_ready_i) begin
      out_valid_next = 1'b0;
    end
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      out_next = mem_reg[rd_ptr_reg];
      out_valid_next = 1'b1;
    end
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = !full;
  assign out_data_o = out_reg;
  assign out_valid_o = out_valid_reg;
endmodule

// ===== hw/sar_adc_serial_readout.sv
// Conversion and serial readout of the successive-approximation core
// Operation
// - Strobe fall ends sampling, starts conversion
// - One approximation step per serial clock pulse
// - Next code bit on each falling edge
// - Sixteen bits belong to current conversion
// - Output code is two's complement
// - Span twice reference over 2^16 steps
// - Most significant bit shifted out first
`timescale 1ns/1ps
module sar_adc_serial_readout #(
  parameter int DATA_W = sar_readout_pkg::DATA_W,
  parameter int FIFO_DEPTH = sar_readout_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic convert_strobe_n_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic [15:0] result_o,
  output logic result_valid_o
);
  // ------------------------------------------------------------
  // Reference clock domain state
  // ------------------------------------------------------------
  logic cnv_s1_reg, cnv_s1_next;
  logic cnv_s2_reg, cnv_s2_next;
  logic cnv_s3_reg, cnv_s3_next;
  logic [15:0] acq_reg, acq_next;
  logic [15:0] hold_reg, hold_next;
  logic frame_tgl_reg, frame_tgl_next;
  logic done_s1_reg, done_s1_next;
  logic done_s2_reg, done_s2_next;
  logic done_s3_reg, done_s3_next;
  logic [15:0] result_out_reg, result_out_next;
  logic result_valid_reg, result_valid_next;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic cnv_fall;

  // ------------------------------------------------------------
  // Serial clock domain state
  // ------------------------------------------------------------
  logic seen_reg = 1'b0;
  logic seen_next;
  logic [15:0] in_reg = 16'h0000;
  logic [15:0] in_next;
  logic [15:0] approx_reg = 16'h0000;
  logic [15:0] approx_next;
  logic [15:0] weight_reg = 16'h0000;
  logic [15:0] weight_next;
  logic [4:0] step_reg = 5'h00;
  logic [4:0] step_next;
  logic sdo_reg = 1'b0;
  logic sdo_next;
  logic [15:0] result_reg = 16'h0000;
  logic [15:0] result_next;
  logic done_tgl_reg = 1'b0;
  logic done_tgl_next;
  logic start;
  logic busy;
  logic decide;
  logic [15:0] cur_w, cur_base, cur_in, trial, kept;

  // ------------------------------------------------------------
  // Sample buffer
  // ------------------------------------------------------------
  sample_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  // Tracking only while the strobe is high
  assign fifo_ready = cnv_s2_reg;
  assign cnv_fall = cnv_s3_reg && !cnv_s2_reg;

  // ------------------------------------------------------------
  // Acquisition, hold and result capture
  // ------------------------------------------------------------
  always_comb begin
    cnv_s1_next = convert_strobe_n_i;
    cnv_s2_next = cnv_s1_reg;
    cnv_s3_next = cnv_s2_reg;
    acq_next = acq_reg;
    hold_next = hold_reg;
    frame_tgl_next = frame_tgl_reg;
    done_s1_next = done_tgl_reg;
    done_s2_next = done_s1_reg;
    done_s3_next = done_s2_reg;
    result_out_next = result_out_reg;
    result_valid_next = 1'b0;
    if (fifo_valid && fifo_ready) begin
      acq_next = fifo_data;
    end
    if (cnv_fall) begin
      hold_next = acq_reg;
      frame_tgl_next = ~frame_tgl_reg;
    end
    if (done_s3_reg != done_s2_reg) begin
      result_out_next = result_reg;
      result_valid_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnv_s1_reg <= 1'b1;
      cnv_s2_reg <= 1'b1;
      cnv_s3_reg <= 1'b1;
      acq_reg <= sar_readout_pkg::ZERO_CODE;
      hold_reg <= sar_readout_pkg::ZERO_CODE;
      frame_tgl_reg <= 1'b0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
      result_out_reg <= sar_readout_pkg::ZERO_CODE;
      result_valid_reg <= 1'b0;
    end else begin
      cnv_s1_reg <= cnv_s1_next;
      cnv_s2_reg <= cnv_s2_next;
      cnv_s3_reg <= cnv_s3_next;
      acq_reg <= acq_next;
      hold_reg <= hold_next;
      frame_tgl_reg <= frame_tgl_next;
      done_s1_reg <= done_s1_next;
      done_s2_reg <= done_s2_next;
      done_s3_reg <= done_s3_next;
      result_out_reg <= result_out_next;
      result_valid_reg <= result_valid_next;
    end
  end

  // ------------------------------------------------------------
  // Successive approximation on the serial clock
  // ------------------------------------------------------------
  always_comb begin
    start = (seen_reg != frame_tgl_reg);
    busy = start || (weight_reg != sar_readout_pkg::ZERO_CODE);
    cur_w = start ? sar_readout_pkg::SIGN_MASK : weight_reg;
    cur_base = start ? sar_readout_pkg::ZERO_CODE : approx_reg;
    cur_in = start ? (hold_reg ^ sar_readout_pkg::SIGN_MASK) : in_reg;
    trial = cur_base | cur_w;
    decide = (cur_in >= trial);
    kept = decide ? trial : cur_base;
    seen_next = seen_reg;
    in_next = in_reg;
    approx_next = approx_reg;
    weight_next = weight_reg;
    step_next = step_reg;
    sdo_next = 1'b0;
    result_next = result_reg;
    done_tgl_next = done_tgl_reg;
    if (busy) begin
      seen_next = frame_tgl_reg;
      in_next = cur_in;
      approx_next = kept;
      weight_next = cur_w >> 1;
      step_next = start ? sar_readout_pkg::FIRST_STEP : step_reg + 5'h01;
      // Sign bit inverted to give two's complement
      sdo_next = (cur_w == sar_readout_pkg::SIGN_MASK) ? ~decide : decide;
      if (cur_w == sar_readout_pkg::LSB_WEIGHT) begin
        result_next = kept ^ sar_readout_pkg::SIGN_MASK;
        done_tgl_next = ~done_tgl_reg;
      end
    end
  end

  always_ff @(negedge sck_i) begin
    seen_reg <= seen_next;
    in_reg <= in_next;
    approx_reg <= approx_next;
    weight_reg <= weight_next;
    step_reg <= step_next;
    sdo_reg <= sdo_next;
    result_reg <= result_next;
    done_tgl_reg <= done_tgl_next;
  end

  assign sdo_o = sdo_reg;
  assign sdo_oe_n_o = convert_strobe_n_i;
  assign result_o = result_out_reg;
  assign result_valid_o = result_valid_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_frame_start;
    (seen_reg != frame_tgl_reg);
  endsequence

  sequence seq_last_step;
    (weight_reg == sar_readout_pkg::LSB_WEIGHT);
  endsequence

  sequence seq_mid_step;
    (!start && (weight_reg != sar_readout_pkg::ZERO_CODE));
  endsequence

  AST_HOLD_ON_FALL: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    cnv_fall |=> (hold_reg == $past(acq_reg)) &&
      (frame_tgl_reg != $past(frame_tgl_reg)))
    else $error("hold word not taken on strobe fall");

  AST_NO_TRACK_IN_CONV: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (!cnv_s2_reg && !cnv_fall) |=> $stable(acq_reg))
    else $error("acquisition moved during conversion");

  AST_WEIGHT_HALVES: assert property (
    @(negedge sck_i) disable iff (convert_strobe_n_i)
    (!start && weight_reg != sar_readout_pkg::ZERO_CODE)
      |=> weight_reg == ($past(weight_reg) >> 1))
    else $error("approximation step skipped");

  AST_FIRST_MSB: assert property (
    @(negedge sck_i) disable iff (convert_strobe_n_i)
    seq_frame_start |=> (sdo_reg == $past(hold_reg[15])) &&
      (step_reg == sar_readout_pkg::FIRST_STEP))
    else $error("first bit is not the sign bit");

  AST_SIXTEEN_STEPS: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_last_step |=> step_reg == sar_readout_pkg::LAST_STEP)
    else $error("conversion not sixteen steps");

  AST_RESULT_MATCH: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_last_step |=> result_reg == (in_reg ^ sar_readout_pkg::SIGN_MASK))
    else $error("result differs from held sample");

  AST_LAST_BIT: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_last_step |=> sdo_reg == result_reg[0])
    else $error("last serial bit differs from result");

  AST_SIGN_CODE: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_last_step |=> result_reg[15] == ~approx_reg[15])
    else $error("result is not two's complement");

  AST_RESULT_PULSE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    result_valid_o |=> !result_valid_o)
    else $error("result valid longer than one cycle");

  AST_TOGGLE_ONLY_ON_FALL: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !cnv_fall |=> $stable(frame_tgl_reg))
    else $error("frame toggle moved without strobe fall");

  AST_HOLD_ONLY_ON_FALL: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !cnv_fall |=> $stable(hold_reg))
    else $error("held word moved during a frame");

  AST_RESULT_CAPTURE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (done_s3_reg != done_s2_reg) |=> result_valid_o &&
      (result_o == $past(result_reg)))
    else $error("result word not passed on after frame");

  AST_START_LOADS: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_frame_start |=>
      (in_reg == ($past(hold_reg) ^ sar_readout_pkg::SIGN_MASK)))
    else $error("frame did not load the held word");

  AST_STEP_ADVANCES: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_mid_step |=> step_reg == ($past(step_reg) + 5'h01))
    else $error("step count did not advance");

  AST_APPROX_BELOW_INPUT: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_mid_step |-> approx_reg <= in_reg)
    else $error("approximation above held input");

  AST_SERIAL_BIT: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_mid_step |=> sdo_reg == |($past(hold_reg) & $past(weight_reg)))
    else $error("serial bit differs from held word");

  AST_SIGN_INVERTED: assert property (
    @(negedge sck_i) disable iff (rst_i)
    seq_frame_start |=> sdo_reg == ~in_reg[15])
    else $error("sign bit not inverted from offset code");
endmodule

// ===== hw/sar_readout_pkg.sv
// Shared constants of the serial converter readout
package sar_readout_pkg;
  // ------------------------------------------------------------
  // Code format
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam logic [15:0] SIGN_MASK = 16'h8000;
  localparam logic [15:0] LSB_WEIGHT = 16'h0001;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [4:0] FIRST_STEP = 5'h01;
  localparam logic [4:0] LAST_STEP = 5'h10;
  // ------------------------------------------------------------
  // Transfer function
  // ------------------------------------------------------------
  localparam int REF_UV = 4096000;
  localparam int CODE_LEVELS = 65536;
  localparam int LSB_UV = (2 * REF_UV) / CODE_LEVELS;
  // ------------------------------------------------------------
  // Sample buffer
  // ------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
endpackage

// ===== verification/host_reader_model.sv
// Host model that strobes a conversion and reads the serial word
`timescale 1ns/1ps
module host_reader_model (
  input wire logic go_i,
  input wire logic hold_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic convert_strobe_n_o,
  output logic [15:0] word_o,
  output logic done_o
);
  logic active;
  initial begin
    sck_o = 1'b0;
    active = 1'b0;
    word_o = 16'h0000;
    done_o = 1'b1;
  end
  // --------------------
  // Frame sequence
  // --------------------
  // Strobe low for a frame or to hold off draining
  assign convert_strobe_n_o = ~(active | hold_i);
  always @(posedge go_i) begin
    done_o = 1'b0;
    #7.3;
    active = 1'b1;
    #60.0;
    // Sixteen pulses, clock stands low outside frames
    for (int i = 0; i < 16; i++) begin
      sck_o = 1'b1;
      #62.5;
      sck_o = 1'b0;
      #62.5;
      // Assembled MSB first, codes passed on unclamped
      word_o = {word_o[14:0], sdo_i};
    end
    #60.0;
    active = 1'b0;
    done_o = 1'b1;
  end
endmodule

// ===== verification/tb_sar_adc_serial_readout.sv
// Self-checking bench of the serial converter readout
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] sample_i = 16'h0000;
  logic sample_valid_i = 1'b0;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic sck, strobe_n, sdo, sdo_oe_n, sdo_line, ready, res_valid, done;
  logic [15:0] result, word;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_pulse = 0;
  int oe_bad = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // Pull-up on the released data line
  assign sdo_line = (sdo_oe_n === 1'b0) ? sdo : 1'b1;
  sar_adc_serial_readout DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck),
    .convert_strobe_n_i(strobe_n), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(ready),
    .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .result_o(result),
    .result_valid_o(res_valid)
  );
  host_reader_model host (
    .go_i(go), .hold_i(hold), .sdo_i(sdo_line), .sck_o(sck),
    .convert_strobe_n_o(strobe_n), .word_o(word), .done_o(done)
  );
  always @(negedge ref_clk_i) begin
    if (res_valid === 1'b1) n_pulse++;
    if (strobe_n === 1'b0 && sdo_oe_n !== 1'b0) oe_bad++;
  end
  // --------------------
  // Shared tasks
  // --------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask
  task automatic push(input logic [15:0] v);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    sample_i = v;
    sample_valid_i = 1'b1;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 50) give_up();
    @(negedge ref_clk_i);
    sample_valid_i = 1'b0;
  endtask
  task automatic frame(input logic [15:0] exp);
    int n, p0;
    n = 0;
    p0 = n_pulse;
    @(negedge ref_clk_i);
    go = 1'b1;
    @(negedge ref_clk_i);
    go = 1'b0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 1000) give_up();
    hold = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk(word, exp);
    chk(result, exp);
    chk(16'(n_pulse - p0), 16'h0001);
    chk({15'h0000, sdo_oe_n}, 16'h0001);
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    chk(result, 16'h0000);
    chk({15'h0000, res_valid}, 16'h0000);
    chk({15'h0000, ready}, 16'h0001);
    chk(16'(sar_readout_pkg::LSB_UV), 16'h007D);
    $display("test reset done");
  endtask
  task automatic t_codes();
    logic [15:0] tbl [6];
    tbl = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h0001, 16'hA5C3};
    foreach (tbl[i]) begin
      push(tbl[i]);
      repeat (10) @(negedge ref_clk_i);
      frame(tbl[i]);
    end
    $display("test codes done");
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    hold = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    sample_i = 16'h1000;
    sample_valid_i = 1'b1;
    while (ready === 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
      sample_i = 16'h1000 + 16'(n);
    end
    sample_valid_i = 1'b0;
    chk(16'(n), 16'h0010);
    // Read out the word held at the strobe fall, then drain
    frame(16'hA5C3);
    repeat (40) @(negedge ref_clk_i);
    chk({15'h0000, ready}, 16'h0001);
    frame(16'h100F);
    $display("test fill done");
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_codes();
    t_fill();
    chk(16'(oe_bad), 16'h0000);
    final_report();
  end
endmodule
